// [verilog/tmr_dual_timer.sv]
// Two 16-bit timer/counters with four modes behind the special-function bus
`timescale 1ns/10ps
module tmr_dual_timer
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic count_pin_a,
    input wire logic count_pin_b,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic timer0_int_ack,
    input wire logic timer1_int_ack,
    output logic timer0_irq,
    output logic timer1_irq,
    output logic timer1_baud_tick
);
    // Count bytes, control and configuration
    logic [7:0] timer0_low_byte;
    logic [7:0] timer0_high_byte;
    logic [7:0] timer1_low_byte;
    logic [7:0] timer1_high_byte;
    logic [7:0] timer_mode;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer0_run;
    logic timer1_run;
    logic timer0_prescale_select;
    logic timer1_prescale_select;

    // Decoded configuration
    tmr_mode_e timer0_mode_field;
    tmr_mode_e timer1_mode_field;
    logic timer0_source_select;
    logic timer1_source_select;
    logic timer0_pin_gate;
    logic timer1_pin_gate;
    logic t0_split;

    // Tick and edge sources
    logic tick0;
    logic tick1;
    logic fall_a;
    logic fall_b;

    // Per-cycle increment requests and results
    logic t0_inc;
    logic t0h_inc;
    logic t1_inc;
    logic [16:0] t0_step;
    logic [16:0] t1_step;
    logic t0h_ovf;
    logic t0_ovf;
    logic t1_ovf;
    logic [7:0] next_t0_low;
    logic [7:0] next_t0_high;
    logic [7:0] next_t1_low;
    logic [7:0] next_t1_high;
    logic set_tf0;
    logic set_tf1;

    // Write strobes
    logic wr_ctrl;
    logic wr_mode;
    logic wr_t0l;
    logic wr_t0h;
    logic wr_t1l;
    logic wr_t1h;
    logic wr_function_setting_reg;

    // One increment of a timer in the given mode; result is {overflow, high, low}
    function automatic logic [16:0] tmr_step(
        input tmr_mode_e mode,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [13:0] sum13;
        logic [16:0] sum16;
        logic [8:0] sum8;
        sum13 = {1'b0, hi, lo[MODE13_LOW_BITS-1:0]} + 14'h0001;
        sum16 = {1'b0, hi, lo} + 17'h00001;
        sum8 = {1'b0, lo} + 9'h001;
        unique case (mode)
            TMR_MODE_13BIT: begin
                tmr_step = {sum13[13], sum13[12:5], lo[7:MODE13_LOW_BITS], sum13[4:0]};
            end
            TMR_MODE_16BIT: begin
                tmr_step = sum16;
            end
            TMR_MODE_RELOAD8: begin
                tmr_step = {sum8[8], hi, sum8[8] ? hi : sum8[7:0]};
            end
            TMR_MODE_SPLIT: begin
                tmr_step = {sum8[8], hi, sum8[7:0]};
            end
        endcase
    endfunction

    // Prescaler and edge detectors, one per timer
    // divide by twelve or bypass
    tmr_prescale u_pre0 (
        .sys_clk(sys_clk),
        .rst(rst),
        .bypass(timer0_prescale_select),
        .tick(tick0)
    );

    tmr_prescale u_pre1 (
        .sys_clk(sys_clk),
        .rst(rst),
        .bypass(timer1_prescale_select),
        .tick(tick1)
    );

    tmr_fall_detect u_fall_a (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin(count_pin_a),
        .fall(fall_a)
    );

    tmr_fall_detect u_fall_b (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin(count_pin_b),
        .fall(fall_b)
    );

    assign timer0_mode_field = tmr_mode_e'(timer_mode[MODE_T0_MSB:MODE_T0_LSB]);
    assign timer1_mode_field = tmr_mode_e'(timer_mode[MODE_T1_MSB:MODE_T1_LSB]);
    assign timer0_source_select = timer_mode[MODE_SEL0_BIT];
    assign timer1_source_select = timer_mode[MODE_SEL1_BIT];
    assign timer0_pin_gate = timer_mode[MODE_TIMER0_PIN_GATE_BIT];
    assign timer1_pin_gate = timer_mode[MODE_TIMER1_PIN_GATE_BIT];
    assign t0_split = (timer0_mode_field == TMR_MODE_SPLIT);

    // Register write decode
    assign wr_ctrl = sfr_wr & (sfr_addr == ADDR_TIMER_CONTROL);
    assign wr_mode = sfr_wr & (sfr_addr == ADDR_TIMER_MODE);
    assign wr_t0l = sfr_wr & (sfr_addr == ADDR_TIMER0_LOW);
    assign wr_t0h = sfr_wr & (sfr_addr == ADDR_TIMER0_HIGH);
    assign wr_t1l = sfr_wr & (sfr_addr == ADDR_TIMER1_LOW);
    assign wr_t1h = sfr_wr & (sfr_addr == ADDR_TIMER1_HIGH);
    assign wr_function_setting_reg = sfr_wr & (sfr_addr == ADDR_FUNCTION_SETTING);

    // Timer 0 enables: run, gate pin and source choice
    always_comb begin
        t0_inc = timer0_run & (~timer0_pin_gate | ext_irq_pin_a)
            & (timer0_source_select ? fall_a : tick0);
        // high byte under timer 1 run, clock ticks only
        t0h_inc = t0_split & timer1_run & tick0;
    end

    // Timer 1 enables; with timer 0 split the mode switch alone starts or stops it
    always_comb begin
        // no pin edges while timer 0 is split
        if (timer1_mode_field == TMR_MODE_SPLIT) begin
            t1_inc = 1'b0;
        end else if (t0_split) begin
            t1_inc = tick1;
        end else begin
            t1_inc = timer1_run & (~timer1_pin_gate | ext_irq_pin_b)
                & (timer1_source_select ? fall_b : tick1);
        end
    end

    // Next count values and overflow events
    always_comb begin
        t0_step = tmr_step(timer0_mode_field, timer0_low_byte, timer0_high_byte);
        t1_step = tmr_step(timer1_mode_field, timer1_low_byte, timer1_high_byte);
        t0_ovf = t0_inc & t0_step[16];
        t1_ovf = t1_inc & t1_step[16];
        t0h_ovf = t0h_inc & (timer0_high_byte == BYTE_ALL_ONES);
        next_t0_low = t0_inc ? t0_step[7:0] : timer0_low_byte;
        if (t0_split) begin
            next_t0_high = t0h_inc ? timer0_high_byte + 8'h01 : timer0_high_byte;
        end else begin
            next_t0_high = t0_inc ? t0_step[15:8] : timer0_high_byte;
        end
        next_t1_low = t1_inc ? t1_step[7:0] : timer1_low_byte;
        next_t1_high = t1_inc ? t1_step[15:8] : timer1_high_byte;
        set_tf0 = t0_ovf;
        // split high byte owns flag 1
        // timer 1 wrap kept off flag 1 while timer 0 is split
        set_tf1 = t0h_ovf | (t1_ovf & ~t0_split);
    end

    // Count bytes; a software write wins over a count in the same cycle
    // byte-addressable count halves
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer0_low_byte <= RESET_BYTE;
            timer0_high_byte <= RESET_BYTE;
            timer1_low_byte <= RESET_BYTE;
            timer1_high_byte <= RESET_BYTE;
        end else begin
            timer0_low_byte <= wr_t0l ? sfr_wdata : next_t0_low;
            timer0_high_byte <= wr_t0h ? sfr_wdata : next_t0_high;
            timer1_low_byte <= wr_t1l ? sfr_wdata : next_t1_low;
            timer1_high_byte <= wr_t1h ? sfr_wdata : next_t1_high;
        end
    end

    // Overflow flags; a hardware set beats a same-cycle clear
    // set, write-zero and vector clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer0_overflow_flag <= 1'b0;
            timer1_overflow_flag <= 1'b0;
        end else begin
            if (set_tf0) begin
                timer0_overflow_flag <= 1'b1;
            end else if (wr_ctrl) begin
                timer0_overflow_flag <= sfr_wdata[CTRL_TF0_BIT];
            end else if (timer0_int_ack) begin
                timer0_overflow_flag <= 1'b0;
            end
            if (set_tf1) begin
                timer1_overflow_flag <= 1'b1;
            end else if (wr_ctrl) begin
                timer1_overflow_flag <= sfr_wdata[CTRL_TF1_BIT];
            end else if (timer1_int_ack) begin
                timer1_overflow_flag <= 1'b0;
            end
        end
    end

    // Run bits, mode register and divider selects
    // control bit layout
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer0_run <= 1'b0;
            timer1_run <= 1'b0;
            timer_mode <= RESET_BYTE;
            timer0_prescale_select <= 1'b0;
            timer1_prescale_select <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                timer0_run <= sfr_wdata[CTRL_TR0_BIT];
                timer1_run <= sfr_wdata[CTRL_TR1_BIT];
            end
            if (wr_mode) begin
                timer_mode <= sfr_wdata;
            end
            if (wr_function_setting_reg) begin
                timer0_prescale_select <= sfr_wdata[FUNCTION_SETTING_REG_TIMER0_PRESCALE_SELECT_BIT];
                timer1_prescale_select <= sfr_wdata[FUNCTION_SETTING_REG_TIMER1_PRESCALE_SELECT_BIT];
            end
        end
    end

    // Baud tick follows timer 1 wrap in every mode, flag or not
    // overflow still feeds the serial port
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer1_baud_tick <= 1'b0;
        end else begin
            timer1_baud_tick <= t1_ovf;
        end
    end

    // Registered read port; unmapped addresses and legacy bits read zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sfr_rdata <= RESET_BYTE;
        end else if (sfr_rd) begin
            sfr_rdata <= RESET_BYTE;
            unique case (sfr_addr)
                ADDR_TIMER_CONTROL: begin
                    sfr_rdata[CTRL_TF1_BIT] <= timer1_overflow_flag;
                    sfr_rdata[CTRL_TR1_BIT] <= timer1_run;
                    sfr_rdata[CTRL_TF0_BIT] <= timer0_overflow_flag;
                    sfr_rdata[CTRL_TR0_BIT] <= timer0_run;
                end
                ADDR_TIMER_MODE: sfr_rdata <= timer_mode;
                ADDR_TIMER0_LOW: sfr_rdata <= timer0_low_byte;
                ADDR_TIMER0_HIGH: sfr_rdata <= timer0_high_byte;
                ADDR_TIMER1_LOW: sfr_rdata <= timer1_low_byte;
                ADDR_TIMER1_HIGH: sfr_rdata <= timer1_high_byte;
                ADDR_FUNCTION_SETTING: begin
                    sfr_rdata[FUNCTION_SETTING_REG_TIMER0_PRESCALE_SELECT_BIT] <= timer0_prescale_select;
                    sfr_rdata[FUNCTION_SETTING_REG_TIMER1_PRESCALE_SELECT_BIT] <= timer1_prescale_select;
                end
                default: sfr_rdata <= RESET_BYTE;
            endcase
        end
    end

    // Interrupt requests are the flags themselves; enables live elsewhere
    assign timer0_irq = timer0_overflow_flag;
    assign timer1_irq = timer1_overflow_flag;
endmodule

// [verilog/tmr_pkg.sv]
// Package with addresses, field positions and modes of the dual timer block
package tmr_pkg;

    // Special-function register addresses
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
    localparam logic [7:0] ADDR_TIMER0_LOW = 8'h8A;
    localparam logic [7:0] ADDR_TIMER1_LOW = 8'h8B;
    localparam logic [7:0] ADDR_TIMER0_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h8D;
    localparam logic [7:0] ADDR_FUNCTION_SETTING = 8'hBF;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] RESET_PRESCALE = 4'h0;

    // Control register bit positions
    localparam int CTRL_TF1_BIT = 7;
    localparam int CTRL_TR1_BIT = 6;
    localparam int CTRL_TF0_BIT = 5;
    localparam int CTRL_TR0_BIT = 4;

    // Mode register field positions
    localparam int MODE_TIMER1_PIN_GATE_BIT = 7;
    localparam int MODE_SEL1_BIT = 6;
    localparam int MODE_T1_MSB = 5;
    localparam int MODE_T1_LSB = 4;
    localparam int MODE_TIMER0_PIN_GATE_BIT = 3;
    localparam int MODE_SEL0_BIT = 2;
    localparam int MODE_T0_MSB = 1;
    localparam int MODE_T0_LSB = 0;

    // Function-setting register divider select positions
    localparam int FUNCTION_SETTING_REG_TIMER0_PRESCALE_SELECT_BIT = 6;
    localparam int FUNCTION_SETTING_REG_TIMER1_PRESCALE_SELECT_BIT = 2;

    // Divider ratio of the slow tick and the low-byte width kept in 13-bit mode
    localparam int PRESCALE_RATIO = 12;
    localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_RATIO - 1);
    localparam int MODE13_LOW_BITS = 5;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;

    // Operating modes, in the order of the two-bit field codes
    typedef enum logic [1:0] {
        TMR_MODE_13BIT,
        TMR_MODE_16BIT,
        TMR_MODE_RELOAD8,
        TMR_MODE_SPLIT
    } tmr_mode_e;

endpackage

// [verilog/tmr_fall_detect.sv]
// Falling-edge detector for an external count pin
`timescale 1ns/10ps
module tmr_fall_detect (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pin,
    output logic fall
);
    logic pin_prev;

    // Previous level starts at the idle-high level; a pin held low out of
    // reset is harmless because every timer is stopped then
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_prev <= 1'b1;
        end else begin
            pin_prev <= pin;
        end
    end

    assign fall = pin_prev & ~pin;
endmodule

// [verilog/tmr_prescale.sv]
// Divide-by-twelve tick generator with bypass
`timescale 1ns/10ps
module tmr_prescale
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bypass,
    output logic tick
);
    logic [3:0] div_cnt;

    // Free-running divider; keeps running in bypass so phase is simple
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_cnt <= RESET_PRESCALE;
        end else if (div_cnt == PRESCALE_LAST) begin
            div_cnt <= RESET_PRESCALE;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    assign tick = bypass | (div_cnt == PRESCALE_LAST);
endmodule

// [tb/tmr_dual_timer_monitor.sv]
// Checker of the dual timer register port and overflow outputs
`timescale 1ns/10ps
module tmr_dual_timer_monitor
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic count_pin_a,
    input wire logic count_pin_b,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic timer0_int_ack,
    input wire logic timer1_int_ack,
    input wire logic timer0_irq,
    input wire logic timer1_irq,
    input wire logic timer1_baud_tick
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic mapped;
    logic [7:0] wdata_q;
    logic ctrl_wr;
    // Address decode and last write data, kept apart from the design
    assign mapped = sfr_addr inside {8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hBF};
    assign ctrl_wr = sfr_wr && sfr_addr == ADDR_TIMER_CONTROL;
    always_ff @(posedge sys_clk) wdata_q <= sfr_wdata;
    // Register port and flag relations
    out_after_reset_a:
    assert property ($fell(rst) |-> !timer0_irq && !timer1_irq && sfr_rdata == 8'h00)
        else $error("outputs not clear after reset");
    ctrl_low_zero_a:
    assert property (sfr_rd && sfr_addr == ADDR_TIMER_CONTROL |=> sfr_rdata[3:0] == 4'h0)
        else $error("control low nibble not zero");
    mode_readback_a:
    assert property (sfr_wr && sfr_addr == ADDR_TIMER_MODE ##1 sfr_rd && sfr_addr ==
        ADDR_TIMER_MODE |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("mode readback");
    function_setting_reg_readback_a:
    assert property (sfr_wr && sfr_addr == ADDR_FUNCTION_SETTING ##1 sfr_rd && sfr_addr ==
        ADDR_FUNCTION_SETTING |=> sfr_rdata == ($past(sfr_wdata, 2) & 8'h44))
        else $error("divider select readback");
    unmapped_zero_a:
    assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00) else $error("unmapped read");
    rdata_hold_a:
    assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
    flag_write_set_a:
    assert property (ctrl_wr && !timer0_int_ack && !timer1_int_ack |=>
        (timer0_irq || !wdata_q[CTRL_TF0_BIT]) && (timer1_irq || !wdata_q[CTRL_TF1_BIT]))
        else $error("flag write of one lost");
    flag_double_clear_a:
    assert property ((ctrl_wr && sfr_wdata == 8'h00)[*2] |=> !timer0_irq && !timer1_irq)
        else $error("flags survive clear");
    flag_hold_a:
    assert property (timer0_irq && !timer0_int_ack && !ctrl_wr |=> timer0_irq)
        else $error("flag dropped by itself");
    // Main scenarios reached
    cover property ($rose(timer0_irq));
    cover property ($rose(timer1_irq));
    cover property (timer1_baud_tick);
endmodule

bind tmr_dual_timer tmr_dual_timer_monitor u_mon (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .count_pin_a, .count_pin_b, .ext_irq_pin_a, .ext_irq_pin_b,
    .timer0_int_ack, .timer1_int_ack, .timer0_irq, .timer1_irq, .timer1_baud_tick);

// [tb/tmr_pin_model.sv]
// Model of the external count and gate pins
`timescale 1ns/10ps
module tmr_pin_model (
    input wire logic sys_clk,
    output logic count_pin_a,
    output logic count_pin_b,
    output logic ext_irq_pin_a,
    output logic ext_irq_pin_b
);
    // Pins idle high so the first low is a real falling edge
    initial begin
        {count_pin_a, count_pin_b, ext_irq_pin_a, ext_irq_pin_b} = 4'hF;
    end
    // falling edges, each level held a full cycle
    task automatic falls(input logic b, input int n);
        for (int i = 0; i < n; i++) begin
            {count_pin_b, count_pin_a} = b ? 2'h1 : 2'h2;
            @(posedge sys_clk);
            #1;
            {count_pin_b, count_pin_a} = 2'h3;
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic gates(input logic a, input logic b);
        {ext_irq_pin_a, ext_irq_pin_b} = {a, b};
    endtask
endmodule

// [tb/tmr_dual_timer_test.sv]
// Self-checking bench of the dual timer block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module tmr_dual_timer_test
    import tmr_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst, sfr_wr, sfr_rd, timer0_int_ack, timer1_int_ack;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val, v;
    logic count_pin_a, count_pin_b, ext_irq_pin_a, ext_irq_pin_b;
    logic timer0_irq, timer1_irq, timer1_baud_tick;
    logic [1:0] seen;
    logic seen_clr;
    logic [7:0] regs [8] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hBF, 8'h8E};
    int err_total, checks, baud_cnt, b, t, m;

    tmr_dual_timer u_dut (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .count_pin_a, .count_pin_b, .ext_irq_pin_a, .ext_irq_pin_b, .timer0_int_ack,
        .timer1_int_ack, .timer0_irq, .timer1_irq, .timer1_baud_tick);
    tmr_pin_model u_pins (.sys_clk, .count_pin_a, .count_pin_b, .ext_irq_pin_a,
        .ext_irq_pin_b);

    always #10 sys_clk = ~sys_clk;
    // Sticky flag record and baud pulse count; single-cycle events are easy to miss
    // Record cleared on request so only this process writes it
    always @(posedge sys_clk) begin
        seen <= seen_clr ? 2'h0 : (seen | {timer1_irq, timer0_irq});
        if (timer1_baud_tick) baud_cnt <= baud_cnt + 1;
    end

    task automatic complete_run();
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Bus cycles; strobe held up between back-to-back transfers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {2'h2, a, d};
        @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        {sfr_wr, sfr_rd, sfr_addr} = {2'h1, a};
        @(posedge sys_clk);
        #1;
        rd_val = sfr_rdata;
    endtask
    task automatic tick(input int n);
        {sfr_wr, sfr_rd} = 2'h0;
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Expected {flag, high, low} after n increments in mode m
    function automatic logic [16:0] step(input logic [1:0] m, input logic [16:0] s, input int n);
        logic [16:0] r;
        logic [12:0] c;
        r = s;
        for (int i = 0; i < n; i++) begin
            case (m)
                2'h0: begin
                    c = {r[15:8], r[4:0]} + 13'h1;
                    r = {r[16] | (c == 13'h0), c[12:5], r[7:5], c[4:0]};
                end
                2'h1: r = {r[16] | (r[15:0] == 16'hFFFF), r[15:0] + 16'h1};
                2'h2: r = (r[7:0] == 8'hFF) ? {1'b1, r[15:8], r[15:8]} : {r[16:8], r[7:0] + 8'h1};
                default: r = {r[16] | (r[7:0] == 8'hFF), r[15:8], r[7:0] + 8'h1};
            endcase
        end
        return r;
    endfunction
    // Load, start, stop one timer; k pin falls or n clock cycles, inc expected steps
    task automatic run(input int t, input logic [7:0] md, input logic [7:0] lo,
        input logic [7:0] hi, input int n, input int k, input int inc);
        logic [1:0] m;
        logic [16:0] e, eh;
        logic [7:0] msk;
        m = t ? md[5:4] : md[1:0];
        msk = (m == 2'h0) ? 8'h1F : 8'hFF;
        e = step(m, {1'b0, hi, lo}, inc);
        eh = step(2'h3, {9'h0, hi}, inc);
        wr(8'h88, 8'h00);
        wr(8'h88, 8'h00);
        wr(8'h89, md);
        wr(t ? 8'h8B : 8'h8A, lo);
        wr(t ? 8'h8D : 8'h8C, hi);
        seen_clr = 1'b1;
        wr(8'h88, t ? 8'h40 : ((m == 2'h3) ? 8'h50 : 8'h10));
        seen_clr = 1'b0;
        if (k > 0) begin
            tick(1);
            u_pins.falls(t[0], k);
            tick(2);
        end else begin
            tick(n - 1);
        end
        wr(8'h88, 8'h00);
        tick(1);
        rd(t ? 8'h8B : 8'h8A);
        `CHK("count low", e[7:0] & msk, rd_val & msk)
        rd(t ? 8'h8D : 8'h8C);
        `CHK("count high", (m == 2'h3) ? eh[7:0] : e[15:8], rd_val)
        `CHK("flags", t ? {e[16], 1'b0} : {(m == 2'h3) & eh[16], e[16]}, seen)
    endtask

    // Hang guard, far beyond the fewer than a thousand cycles the tests need
    initial begin
        #400000;
        err_total++;
        complete_run();
    end

    initial begin
        {rst, sfr_wr, sfr_rd, timer0_int_ack, timer1_int_ack} = 5'h10;
        {sfr_addr, sfr_wdata, seen_clr} = 17'h1;
        {err_total, checks} = {32'h0, 32'h0};
        void'($urandom(96));
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        foreach (regs[i]) begin
            rd(regs[i]);
            `CHK("reset value", 8'h00, rd_val)
        end
        repeat (4) begin
            v = 8'($urandom);
            wr(8'h89, v);
            rd(8'h89);
            `CHK("mode", v, rd_val)
        end
        wr(8'h89, 8'h00);
        wr(8'h88, 8'hA0);
        rd(8'h88);
        `CHK("control", 8'hA0, rd_val)
        {timer1_int_ack, timer0_int_ack} = 2'h3;
        tick(1);
        {timer1_int_ack, timer0_int_ack} = 2'h0;
        `CHK("ack clear", 2'h0, {timer1_irq, timer0_irq})
        run(0, 8'h01, 8'h00, 8'h00, 48, 0, 4);
        wr(8'hBF, 8'hFF);
        rd(8'hBF);
        `CHK("divider select", 8'h44, rd_val)
        run(0, 8'h00, 8'h1F, 8'hFF, 2, 0, 2);
        run(1, 8'h10, 8'hFF, 8'hFF, 2, 0, 2);
        run(0, 8'h02, 8'hFF, 8'hC5, 2, 0, 2);
        for (int i = 0; i < 12; i++) begin
            t = $urandom_range(0, 1);
            m = t ? $urandom_range(0, 2) : $urandom_range(0, 3);
            v = t ? 8'(m << 4) : ((m == 3) ? 8'h33 : 8'(m));
            b = $urandom_range(2, 40);
            run(t, v, 8'hE0 | 8'($urandom_range(0, 31)), $urandom_range(0, 1) ? 8'hFF :
                8'($urandom), b, 0, b);
        end
        for (int i = 0; i < 2; i++) begin
            b = $urandom_range(3, 6);
            run(i, i ? 8'h50 : 8'h05, 8'hFE, 8'hFF, 0, b, b);
            u_pins.gates(1'b0, 1'b0);
            run(i, i ? 8'h90 : 8'h09, 8'h10, 8'h00, 10, 0, 0);
            u_pins.gates(1'b1, 1'b1);
            run(i, i ? 8'h90 : 8'h09, 8'h10, 8'h00, 10, 0, 10);
        end
        wr(8'h89, 8'h33);
        wr(8'h8B, 8'hFE);
        wr(8'h8D, 8'hFF);
        tick(20);
        rd(8'h8B);
        `CHK("held count", 8'hFE, rd_val)
        b = baud_cnt;
        seen_clr = 1'b1;
        wr(8'h89, 8'h13);
        seen_clr = 1'b0;
        tick(20);
        `CHK("timer1 flag", 1'b0, seen[1])
        `CHK("baud tick", 1'b1, baud_cnt > b)
        complete_run();
    end
endmodule
